/* srq_defs.svh */
`ifndef SRQ_DEFS_SVH
`define SRQ_DEFS_SVH

// Status byte bit positions
`define STB_OPER 7
`define STB_RQS 6
`define STB_ESB 5
`define STB_MAV 4
`define STB_QUES 3
`define STB_HW2 1
`define STB_HW1 0

// Mask write keeps every bit except the request-service position
`define SRE_WR_MASK 8'hbf
`define SRE_RESET 8'h00

// Register group indices
`define GRP_STD 3'h0
`define GRP_OPER 3'h1
`define GRP_QUES 3'h2
`define GRP_HW1 3'h3
`define GRP_HW2 3'h4
`define GRP_CAL 3'h5
`define GRP_COUNT 6

// Questionable condition bit fed by the calibration summary
`define QUES_CAL_BIT 8

// Calibration condition bits
`define CAL_TX_AUTOZERO 4
`define CAL_VOLTMETER 3
`define CAL_COUNTER 2
`define CAL_SAMPLER 1
`define CAL_ANALYZER 0

// Standard event error bits
`define ESR_CMD_ERR 5
`define ESR_EXEC_ERR 4
`define ESR_DEV_ERR 3
`define ESR_QUERY_ERR 2

// Accepted write ranges and the data-out-of-range code (-222)
`define MAX_VAL8 32'sh0000_00ff
`define MAX_VAL16 32'sh0000_ffff
`define ERR_DATA_RANGE 16'hff22

// Transition filter reset values
`define PTR_RESET 16'hffff
`define NTR_RESET 16'h0000

`endif

/* srq_pkg.sv */
package srq_pkg;

  // Decoded common and status commands
  typedef enum logic [3:0] {
    CMD_SRE_WR = 4'h0,
    CMD_SRE_RD = 4'h1,
    CMD_STB_RD = 4'h2,
    CMD_CLS = 4'h3,
    CMD_EVT_RD = 4'h4,
    CMD_COND_RD = 4'h5,
    CMD_ENAB_WR = 4'h6,
    CMD_ENAB_RD = 4'h7,
    CMD_PTR_WR = 4'h8,
    CMD_PTR_RD = 4'h9,
    CMD_NTR_WR = 4'ha,
    CMD_NTR_RD = 4'hb
  } cmd_e;

endpackage : srq_pkg

/* reg_group.sv */
`timescale 1ns/1ns
`default_nettype none
`include "srq_defs.svh"

module reg_group #(
  parameter int WIDTH = 16,
  parameter bit HAS_COND = 1'b1
) (
  input wire logic ref_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] cond, // Condition levels
  input wire logic [WIDTH-1:0] evt_set, // Direct event set pulses
  input wire logic [WIDTH-1:0] wdata, // Write data for filters and enable
  input wire logic ptr_we, // Positive filter write
  input wire logic ntr_we, // Negative filter write
  input wire logic enab_we, // Enable mask write
  input wire logic evt_clr, // Event latch clear
  output logic [WIDTH-1:0] event_q, // Event latch
  output logic [WIDTH-1:0] enable_q, // Enable mask
  output logic [WIDTH-1:0] ptr_q, // Positive transition filter
  output logic [WIDTH-1:0] ntr_q, // Negative transition filter
  output logic summary // Group summary
);

  logic [WIDTH-1:0] cond_q;
  logic [WIDTH-1:0] hit;

  // Previous condition for edge detection
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      cond_q <= '0;
    else
      cond_q <= cond;
  end

  // Filtered transitions, or direct events when no condition register
  always_comb
  begin
    if (HAS_COND)
      hit = ((cond & ~cond_q & ptr_q) | (~cond & cond_q & ntr_q)) | evt_set;
    else
      hit = evt_set;
  end

  // Sticky event latch; a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      event_q <= '0;
    else
      event_q <= (evt_clr ? '0 : event_q) | hit;
  end

  // Filters and enable mask
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ptr_q <= WIDTH'(`PTR_RESET);
      ntr_q <= WIDTH'(`NTR_RESET);
      enable_q <= '0;
    end
    else
    begin
      if (ptr_we)
        ptr_q <= wdata;
      if (ntr_we)
        ntr_q <= wdata;
      if (enab_we)
        enable_q <= wdata;
    end
  end

  assign summary = |(event_q & enable_q);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_event_holds: assert property (!evt_clr |=> (event_q & $past(event_q)) == $past(event_q))
    else $error("event latch lost a bit without a clear");

endmodule : reg_group
`default_nettype wire

/* service_request_enable_logic.sv */
// Notes on behaviour
// - An eight-bit mask holds one enable per status byte summary bit.
// - Service is requested only for summary bits whose mask bit is set.
// - A mask query returns the mask value as an unsigned number 0 to 63 or 128 to 191.
// - A mask write loads bits 0 to 5 and bit 7 from the written value.
// - Bit 6 of a written value is dropped and never enables a request.
// - A mask value below 0 or above 255 is refused with error code -222.
// - Writing zero clears the mask and stops all service requests.
// - A condition change reaches the event latch only if its filter allows it.
// - A group summary is set while any latched event is enabled.
// - Groups without conditions set their event bits directly.
// - The calibration summary drives questionable condition bit 8.
// - Calibration conditions 4..0 flag auto-zero, voltmeter, counter, sampler, analyzer.
// - Standard event bits 5..2 flag command, execution, device and query errors.
// - Requesting service sets the request bit, and a serial poll clears it.
// - Event latches clear on query and on clear-status, and hold until then.
// - Status byte bits carry the operation, event, message, questionable, hardware summaries.
`timescale 1ns/1ns
`default_nettype none
`include "srq_defs.svh"

module service_request_enable_logic (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic cmd_valid, // Decoded command strobe
  input wire srq_pkg::cmd_e cmd_code, // Command kind
  input wire logic [2:0] cmd_group, // Target register group
  input wire logic signed [31:0] cmd_data, // Signed integer argument
  input wire logic [15:0] oper_cond, // Operation conditions
  input wire logic [15:0] ques_cond, // Questionable conditions
  input wire logic [15:0] hw1_cond, // Hardware 1 conditions
  input wire logic [15:0] hw2_cond, // Hardware 2 conditions
  input wire logic cal_tx_autozero_fail, // Auto-zero failure
  input wire logic cal_voltmeter_fail, // Voltmeter self-cal failure
  input wire logic cal_counter_fail, // Counter self-cal failure
  input wire logic cal_sampler_fail, // Sampler self-cal failure
  input wire logic cal_analyzer_fail, // Analyzer self-cal failure
  input wire logic cmd_error, // Command error pulse
  input wire logic exec_error, // Execution error pulse
  input wire logic dev_error, // Device error pulse
  input wire logic query_error, // Query error pulse
  input wire logic msg_available, // Output queue not empty
  input wire logic poll_req, // Serial poll pulse
  output logic resp_valid_q, // Query answer strobe
  output logic [15:0] resp_data_q, // Query answer value
  output logic err_valid_q, // Error strobe
  output logic [15:0] err_code_q, // Error code, two's complement
  output logic poll_valid_q, // Serial poll answer strobe
  output logic [7:0] poll_byte_q, // Serial poll status byte
  output logic srq_o_q, // Request line level when driven
  output logic srq_oe_n_q, // Request line enable, low drives
  output logic [7:0] service_request_mask_q // Mask value
);

  logic [15:0] cond_in [`GRP_COUNT];
  logic [15:0] evt_in [`GRP_COUNT];
  logic [15:0] grp_event [`GRP_COUNT];
  logic [15:0] grp_enable [`GRP_COUNT];
  logic [15:0] grp_ptr [`GRP_COUNT];
  logic [15:0] grp_ntr [`GRP_COUNT];
  logic [`GRP_COUNT-1:0] grp_sum;
  logic [`GRP_COUNT-1:0] ptr_we;
  logic [`GRP_COUNT-1:0] ntr_we;
  logic [`GRP_COUNT-1:0] enab_we;
  logic [`GRP_COUNT-1:0] evt_clr;
  logic is_cmd_sre_wr;
  logic is_grp_wr;
  logic in_range;
  logic range_err;
  logic [7:0] stb;
  logic mss;
  logic mss_q;
  logic mss_rise;
  logic rqs_q;
  logic rqs_d;
  logic [15:0] resp_d;
  logic resp_any;

  // Condition inputs per group; calibration feeds questionable bit 8
  always_comb
  begin
    cond_in[`GRP_STD] = '0;
    cond_in[`GRP_OPER] = oper_cond;
    cond_in[`GRP_QUES] = ques_cond;
    cond_in[`GRP_QUES][`QUES_CAL_BIT] = grp_sum[`GRP_CAL];
    cond_in[`GRP_HW1] = hw1_cond;
    cond_in[`GRP_HW2] = hw2_cond;
    cond_in[`GRP_CAL] = '0;
    cond_in[`GRP_CAL][`CAL_TX_AUTOZERO] = cal_tx_autozero_fail;
    cond_in[`GRP_CAL][`CAL_VOLTMETER] = cal_voltmeter_fail;
    cond_in[`GRP_CAL][`CAL_COUNTER] = cal_counter_fail;
    cond_in[`GRP_CAL][`CAL_SAMPLER] = cal_sampler_fail;
    cond_in[`GRP_CAL][`CAL_ANALYZER] = cal_analyzer_fail;
  end

  // Direct error events; a refused write also counts as an execution error
  always_comb
  begin
    for (int i = 0; i < `GRP_COUNT; i++)
      evt_in[i] = '0;
    evt_in[`GRP_STD][`ESR_CMD_ERR] = cmd_error;
    evt_in[`GRP_STD][`ESR_EXEC_ERR] = exec_error | range_err;
    evt_in[`GRP_STD][`ESR_DEV_ERR] = dev_error;
    evt_in[`GRP_STD][`ESR_QUERY_ERR] = query_error;
  end

  // Argument range check; mask and standard enable are eight bits wide
  assign is_cmd_sre_wr = cmd_valid && (cmd_code == srq_pkg::CMD_SRE_WR);
  assign is_grp_wr = cmd_valid && ((cmd_code == srq_pkg::CMD_ENAB_WR) ||
                     (cmd_code == srq_pkg::CMD_PTR_WR) || (cmd_code == srq_pkg::CMD_NTR_WR));
  always_comb
  begin
    if (is_cmd_sre_wr || (cmd_group == `GRP_STD))
      in_range = (cmd_data >= 0) && (cmd_data <= `MAX_VAL8);
    else
      in_range = (cmd_data >= 0) && (cmd_data <= `MAX_VAL16);
  end
  assign range_err = (is_cmd_sre_wr || is_grp_wr) && !in_range;

  // Per-group write and clear strobes
  always_comb
  begin
    for (int i = 0; i < `GRP_COUNT; i++)
    begin
      ptr_we[i] = cmd_valid && in_range && (cmd_code == srq_pkg::CMD_PTR_WR) &&
                  (cmd_group == 3'(i));
      ntr_we[i] = cmd_valid && in_range && (cmd_code == srq_pkg::CMD_NTR_WR) &&
                  (cmd_group == 3'(i));
      enab_we[i] = cmd_valid && in_range && (cmd_code == srq_pkg::CMD_ENAB_WR) &&
                   (cmd_group == 3'(i));
      evt_clr[i] = cmd_valid && ((cmd_code == srq_pkg::CMD_CLS) ||
                   ((cmd_code == srq_pkg::CMD_EVT_RD) && (cmd_group == 3'(i))));
    end
  end

  // Register groups; the standard event group has no condition register
  genvar g;
  generate
    for (g = 0; g < `GRP_COUNT; g++)
    begin : grp
      reg_group #(
        .WIDTH(16),
        .HAS_COND(g != `GRP_STD)
      ) u_group (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cond(cond_in[g]),
        .evt_set(evt_in[g]),
        .wdata(cmd_data[15:0]),
        .ptr_we(ptr_we[g]),
        .ntr_we(ntr_we[g]),
        .enab_we(enab_we[g]),
        .evt_clr(evt_clr[g]),
        .event_q(grp_event[g]),
        .enable_q(grp_enable[g]),
        .ptr_q(grp_ptr[g]),
        .ntr_q(grp_ntr[g]),
        .summary(grp_sum[g])
      );
    end
  endgenerate

  // Status byte summaries; bit 6 and bit 2 carry no summary
  always_comb
  begin
    stb = '0;
    stb[`STB_OPER] = grp_sum[`GRP_OPER];
    stb[`STB_ESB] = grp_sum[`GRP_STD];
    stb[`STB_MAV] = msg_available;
    stb[`STB_QUES] = grp_sum[`GRP_QUES];
    stb[`STB_HW2] = grp_sum[`GRP_HW2];
    stb[`STB_HW1] = grp_sum[`GRP_HW1];
  end

  // Master summary: only enabled summary bits count
  assign mss = |(stb & service_request_mask_q);
  assign mss_rise = mss && !mss_q;

  // Service request mask, written by the mask command
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      service_request_mask_q <= `SRE_RESET;
    else if (is_cmd_sre_wr && in_range)
      service_request_mask_q <= cmd_data[7:0] & `SRE_WR_MASK;
  end

  // Request-service bit: a new reason sets it, a poll or a lost reason clears it
  assign rqs_d = mss_rise || (rqs_q && mss && !poll_req);
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      mss_q <= 1'b0;
      rqs_q <= 1'b0;
      srq_o_q <= 1'b0;
      srq_oe_n_q <= 1'b1;
    end
    else
    begin
      mss_q <= mss;
      rqs_q <= rqs_d;
      srq_o_q <= 1'b0;
      srq_oe_n_q <= !rqs_d;
    end
  end

  // Serial poll answer carries the request bit in position 6
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      poll_valid_q <= 1'b0;
      poll_byte_q <= '0;
    end
    else
    begin
      poll_valid_q <= poll_req;
      if (poll_req)
      begin
        poll_byte_q <= stb;
        poll_byte_q[`STB_RQS] <= rqs_q;
      end
    end
  end

  // Query answer selection
  always_comb
  begin
    resp_d = '0;
    resp_any = cmd_valid;
    case (cmd_code)
      srq_pkg::CMD_SRE_RD: resp_d = {8'h00, service_request_mask_q};
      srq_pkg::CMD_STB_RD: resp_d = {8'h00, stb | (8'(mss) << `STB_RQS)};
      srq_pkg::CMD_EVT_RD: resp_d = (cmd_group < `GRP_COUNT) ? grp_event[cmd_group] : '0;
      srq_pkg::CMD_COND_RD: resp_d = (cmd_group < `GRP_COUNT) ? cond_in[cmd_group] : '0;
      srq_pkg::CMD_ENAB_RD: resp_d = (cmd_group < `GRP_COUNT) ? grp_enable[cmd_group] : '0;
      srq_pkg::CMD_PTR_RD: resp_d = (cmd_group < `GRP_COUNT) ? grp_ptr[cmd_group] : '0;
      srq_pkg::CMD_NTR_RD: resp_d = (cmd_group < `GRP_COUNT) ? grp_ntr[cmd_group] : '0;
      default: resp_any = 1'b0;
    endcase
  end

  // Answer and error strobes
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      resp_valid_q <= 1'b0;
      resp_data_q <= '0;
      err_valid_q <= 1'b0;
      err_code_q <= '0;
    end
    else
    begin
      resp_valid_q <= resp_any;
      if (resp_any)
        resp_data_q <= resp_d;
      err_valid_q <= range_err;
      if (range_err)
        err_code_q <= `ERR_DATA_RANGE;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_mask_bit_six: assert property (service_request_mask_q[`STB_RQS] == 1'b0)
    else $error("mask bit 6 is set");

  a_mask_write_load: assert property (is_cmd_sre_wr && in_range |=>
    service_request_mask_q == ($past(cmd_data[7:0]) & `SRE_WR_MASK))
    else $error("mask write did not load bits 0-5 and 7");

  a_mask_zero_clear: assert property (is_cmd_sre_wr && cmd_data == 0 |=>
    service_request_mask_q == 8'h00 ##1 srq_oe_n_q)
    else $error("zero write left mask or request active");

  a_range_refused: assert property (is_cmd_sre_wr && !in_range |=>
    err_valid_q && err_code_q == `ERR_DATA_RANGE && $stable(service_request_mask_q))
    else $error("out of range mask value not refused");

  a_mask_query: assert property (cmd_valid && cmd_code == srq_pkg::CMD_SRE_RD |=>
    resp_valid_q && resp_data_q == {8'h00, $past(service_request_mask_q)})
    else $error("mask query answer wrong");

  a_srq_needs_mask: assert property (!srq_oe_n_q |-> $past(mss))
    else $error("request driven with no enabled summary");

  a_srq_on_rise: assert property (mss_rise |=> !srq_oe_n_q && rqs_q)
    else $error("enabled summary rise did not raise request");

  a_poll_clears: assert property (poll_req && !mss_rise |=> srq_oe_n_q && !rqs_q)
    else $error("serial poll did not clear request bit");

  a_poll_byte: assert property (poll_req |=>
    poll_valid_q && poll_byte_q[`STB_RQS] == $past(rqs_q))
    else $error("poll byte request bit wrong");

  a_cal_feeds_ques: assert property (grp_sum[`GRP_CAL] && !$past(grp_sum[`GRP_CAL]) &&
    grp_ptr[`GRP_QUES][`QUES_CAL_BIT] |=> grp_event[`GRP_QUES][`QUES_CAL_BIT])
    else $error("calibration summary did not reach questionable event");

endmodule : service_request_enable_logic
`default_nettype wire

/* bus_controller_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Bus controller side: issues decoded commands and serial polls
module bus_controller_model (
  input wire logic ref_clk, // Clock
  output logic cmd_valid, // Command strobe
  output srq_pkg::cmd_e cmd_code, // Command kind
  output logic [2:0] cmd_group, // Target group
  output logic signed [31:0] cmd_data, // Argument
  output logic poll_req, // Serial poll pulse
  input wire logic resp_valid_q, // Answer strobe
  input wire logic [15:0] resp_data_q, // Answer value
  input wire logic err_valid_q, // Refusal strobe
  input wire logic poll_valid_q, // Poll answer strobe
  input wire logic [7:0] poll_byte_q // Poll status byte
);
  // Idle bus from time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = srq_pkg::CMD_CLS;
    cmd_group = 3'h0;
    cmd_data = 32'sh0000_0000;
    poll_req = 1'b0;
  end

  // One command over one taking edge; qualifiers scrambled once released
  task automatic send(input srq_pkg::cmd_e code, input logic [2:0] grp,
    input logic signed [31:0] data, output logic rv, output logic [15:0] rd,
    output logic ev);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_group = grp;
    cmd_data = data;
    @(posedge ref_clk);
    #1;
    rv = resp_valid_q;
    rd = resp_data_q;
    ev = err_valid_q;
    cmd_valid = 1'b0;
    cmd_group = ~grp;
    cmd_data = ~data;
  endtask : send

  // One serial poll, answer taken in the cycle it stands
  task automatic poll(output logic pv, output logic [7:0] pb);
    @(posedge ref_clk);
    #1;
    poll_req = 1'b1;
    @(posedge ref_clk);
    #1;
    poll_req = 1'b0;
    pv = poll_valid_q;
    pb = poll_byte_q;
  endtask : poll
endmodule : bus_controller_model

`default_nettype wire

/* service_request_enable_logic_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module service_request_enable_logic_tb;
  typedef struct {logic signed [31:0] d; logic [7:0] m; logic e;} row_s;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid;
  srq_pkg::cmd_e cmd_code;
  logic [2:0] cmd_group;
  logic signed [31:0] cmd_data;
  logic poll_req;
  logic [15:0] oper_cond = 16'h0000;
  logic [15:0] ques_cond = 16'h0000;
  logic [15:0] hw1_cond = 16'h0000;
  logic [15:0] hw2_cond = 16'h0000;
  logic [4:0] cal_v = 5'h00;
  logic [3:0] errs = 4'h0;
  logic msg_available = 1'b0;
  logic resp_valid_q, err_valid_q, poll_valid_q, srq_o_q, srq_oe_n_q;
  logic [15:0] resp_data_q, err_code_q;
  logic [7:0] poll_byte_q, service_request_mask_q;
  logic rv, ev, pv;
  logic [15:0] rd;
  logic [7:0] pb;
  int err_count = 0;
  int num_checks = 0;
  int cyc_count = 0;
  row_s rows[9] = '{
    '{32'sh0000_0012, 8'h12, 1'b0},
    '{32'sh0000_00ff, 8'hbf, 1'b0},
    '{32'sh0000_0040, 8'h00, 1'b0},
    '{32'sh0000_0080, 8'h80, 1'b0},
    '{32'sh0000_003f, 8'h3f, 1'b0},
    '{32'sh0000_0100, 8'h3f, 1'b1},
    '{32'shffff_ffff, 8'h3f, 1'b1},
    '{32'sh0000_0000, 8'h00, 1'b0},
    '{32'sh0000_0001, 8'h01, 1'b0}
  };

  always #2 ref_clk = ~ref_clk;

  service_request_enable_logic service_request_enable_logic_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_group(cmd_group), .cmd_data(cmd_data), .oper_cond(oper_cond),
    .ques_cond(ques_cond), .hw1_cond(hw1_cond), .hw2_cond(hw2_cond),
    .cal_tx_autozero_fail(cal_v[4]), .cal_voltmeter_fail(cal_v[3]),
    .cal_counter_fail(cal_v[2]), .cal_sampler_fail(cal_v[1]),
    .cal_analyzer_fail(cal_v[0]), .cmd_error(errs[3]), .exec_error(errs[2]),
    .dev_error(errs[1]), .query_error(errs[0]), .msg_available(msg_available),
    .poll_req(poll_req), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
    .err_valid_q(err_valid_q), .err_code_q(err_code_q), .poll_valid_q(poll_valid_q),
    .poll_byte_q(poll_byte_q), .srq_o_q(srq_o_q), .srq_oe_n_q(srq_oe_n_q),
    .service_request_mask_q(service_request_mask_q));

  bus_controller_model bus_controller_model_inst (
    .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_group(cmd_group), .cmd_data(cmd_data), .poll_req(poll_req),
    .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q), .err_valid_q(err_valid_q),
    .poll_valid_q(poll_valid_q), .poll_byte_q(poll_byte_q));

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk

  task automatic cmd(input srq_pkg::cmd_e c, input logic [2:0] g, input logic signed [31:0] d);
    bus_controller_model_inst.send(c, g, d, rv, rd, ev);
  endtask : cmd

  // Query and compare the answer
  task automatic qry(input srq_pkg::cmd_e c, input logic [2:0] g, input logic [15:0] e,
    input string n);
    cmd(c, g, 32'sh0000_0000);
    chk({n, "_valid"}, 16'h0001, 16'(rv));
    chk(n, e, rd);
  endtask : qry

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Cuts a hang short
  always @(posedge ref_clk)
  begin
    cyc_count++;
    if (cyc_count == 4000)
    begin
      err_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial
  begin
    cyc(16);
    reset_n = 1'b1;
    chk("mask_reset", 16'h0000, 16'(service_request_mask_q));
    chk("srq_reset", 16'h0001, 16'(srq_oe_n_q));
    $display("test reset done");
    foreach (rows[i])
    begin
      cmd(srq_pkg::CMD_SRE_WR, 3'h0, rows[i].d);
      chk("err_valid", 16'(rows[i].e), 16'(ev));
      if (rows[i].e)
        chk("err_code", 16'hff22, err_code_q);
      qry(srq_pkg::CMD_SRE_RD, 3'h0, 16'(rows[i].m), "mask_read");
      chk("mask_port", 16'(rows[i].m), 16'(service_request_mask_q));
    end
    cmd(srq_pkg::CMD_SRE_WR, 3'h0, 32'sh0000_0000);
    $display("test mask_table done");
    cmd(srq_pkg::CMD_CLS, 3'h0, 32'sh0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      errs = 4'h1 << i;
      cyc(1);
      errs = 4'h0;
      qry(srq_pkg::CMD_EVT_RD, 3'h0, 16'h0004 << i, "std_event");
      qry(srq_pkg::CMD_EVT_RD, 3'h0, 16'h0000, "std_cleared");
    end
    cmd(srq_pkg::CMD_SRE_WR, 3'h0, 32'sh0000_0100);
    qry(srq_pkg::CMD_EVT_RD, 3'h0, 16'h0010, "refused_exec");
    $display("test std_events done");
    // Masked summary must not request, unmasking it must
    cmd(srq_pkg::CMD_ENAB_WR, 3'h4, 32'sh0000_0001);
    hw2_cond = 16'h0001;
    cyc(4);
    chk("srq_masked", 16'h0001, 16'(srq_oe_n_q));
    cmd(srq_pkg::CMD_SRE_WR, 3'h0, 32'sh0000_0002);
    cyc(2);
    chk("srq_drive", 16'h0000, 16'(srq_oe_n_q));
    chk("srq_level", 16'h0000, 16'(srq_o_q));
    bus_controller_model_inst.poll(pv, pb);
    chk("poll_valid", 16'h0001, 16'(pv));
    chk("poll_byte", 16'h0042, 16'(pb));
    chk("srq_release", 16'h0001, 16'(srq_oe_n_q));
    bus_controller_model_inst.poll(pv, pb);
    chk("repoll_byte", 16'h0002, 16'(pb));
    cmd(srq_pkg::CMD_CLS, 3'h0, 32'sh0000_0000);
    cmd(srq_pkg::CMD_SRE_WR, 3'h0, 32'sh0000_0000);
    $display("test service_request done");
    // Only the falling edge is passed
    cmd(srq_pkg::CMD_PTR_WR, 3'h4, 32'sh0000_0000);
    cmd(srq_pkg::CMD_NTR_WR, 3'h4, 32'sh0000_0001);
    hw2_cond = 16'h0000;
    cyc(2);
    qry(srq_pkg::CMD_EVT_RD, 3'h4, 16'h0001, "fall_pass");
    hw2_cond = 16'h0001;
    cyc(2);
    qry(srq_pkg::CMD_EVT_RD, 3'h4, 16'h0000, "rise_block");
    // Filter read-back, reset values of an untouched group, refused group writes
    qry(srq_pkg::CMD_PTR_RD, 3'h4, 16'h0000, "ptr_read");
    qry(srq_pkg::CMD_NTR_RD, 3'h4, 16'h0001, "ntr_read");
    qry(srq_pkg::CMD_PTR_RD, 3'h1, 16'hffff, "ptr_reset");
    qry(srq_pkg::CMD_NTR_RD, 3'h1, 16'h0000, "ntr_reset");
    cmd(srq_pkg::CMD_ENAB_WR, 3'h0, 32'sh0000_0100);
    chk("std_enab_refused", 16'h0001, 16'(ev));
    qry(srq_pkg::CMD_ENAB_RD, 3'h0, 16'h0000, "std_enab_kept");
    cmd(srq_pkg::CMD_PTR_WR, 3'h1, 32'sh0001_0000);
    chk("ptr_refused", 16'h0001, 16'(ev));
    qry(srq_pkg::CMD_PTR_RD, 3'h1, 16'hffff, "ptr_kept");
    qry(srq_pkg::CMD_EVT_RD, 3'h0, 16'h0010, "refused_grp");
    $display("test filters done");
    // Calibration summary reaches the status byte through questionable bit 8
    msg_available = 1'b1;
    cmd(srq_pkg::CMD_ENAB_WR, 3'h5, 32'sh0000_001f);
    cmd(srq_pkg::CMD_ENAB_WR, 3'h2, 32'sh0000_0100);
    cmd(srq_pkg::CMD_SRE_WR, 3'h0, 32'sh0000_0008);
    qry(srq_pkg::CMD_ENAB_RD, 3'h5, 16'h001f, "cal_enab_read");
    for (int i = 0; i < 5; i++)
    begin
      cal_v = 5'h01 << i;
      cyc(1);
      qry(srq_pkg::CMD_COND_RD, 3'h5, 16'h0001 << i, "cal_cond");
    end
    cyc(4);
    qry(srq_pkg::CMD_COND_RD, 3'h2, 16'h0100, "ques_cond");
    qry(srq_pkg::CMD_STB_RD, 3'h0, 16'h0058, "status_byte");
    chk("srq_cal", 16'h0000, 16'(srq_oe_n_q));
    $display("test calibration done");
    // Mid-run reset returns mask, request line and filters to reset values
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    chk("mask_rereset", 16'h0000, 16'(service_request_mask_q));
    chk("srq_rereset", 16'h0001, 16'(srq_oe_n_q));
    qry(srq_pkg::CMD_PTR_RD, 3'h4, 16'hffff, "ptr_rereset");
    qry(srq_pkg::CMD_SRE_RD, 3'h0, 16'h0000, "mask_read_rereset");
    $display("test rereset done");
    give_verdict();
  end
endmodule : service_request_enable_logic_tb

`default_nettype wire
